// File: sysprot_pkg.sv
package sysprot_pkg;

  // ==========================================================================
  // Bus carriers
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] dat;
  } wb_rsp_t;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFS_PROTECT_KEY  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RAM_SIZE_SEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLASH_CYCLE  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS       = 8'h0C;

  // ==========================================================================
  // Protection key
  // ==========================================================================
  localparam logic [15:0] PROTECT_UNLOCK_KEY = 16'h0096;
  localparam logic [15:0] PROTECT_KEY_RESET  = 16'h0000;

  // ==========================================================================
  // RAM size select fields
  // ==========================================================================
  localparam int          RAM_CODE_LSB       = 0;
  localparam int          RAM_CODE_W         = 3;
  localparam logic [2:0]  RAM_CODE_RESET     = 3'h3;
  localparam logic [2:0]  RAM_CODE_MAX_LEGAL = 3'h3;
  localparam int          RAM_RSVD_WR_POS    = 8;
  localparam logic        RAM_RSVD_WR_RESET  = 1'b0;
  localparam int          RAM_RSVD_RO_LSB    = 4;
  localparam logic [2:0]  RAM_RSVD_RO_VALUE  = 3'h3;
  localparam logic [15:0] RAM_MIN_BYTES      = 16'h0200;

  // ==========================================================================
  // Flash read cycle fields
  // ==========================================================================
  localparam int          FLASH_WAIT_LSB     = 0;
  localparam int          FLASH_WAIT_W       = 2;
  localparam logic [1:0]  FLASH_WAIT_RESET   = 2'h0;
  localparam int          FLASH_READY_POS    = 7;
  localparam logic        FLASH_READY_RESET  = 1'b0;

  // ==========================================================================
  // Status fields
  // ==========================================================================
  localparam int STAT_PROTECT_ON_POS   = 0;
  localparam int STAT_BLOCKED_WR_POS   = 1;
  localparam int STAT_RAM_ILLEGAL_POS  = 2;
  localparam int STAT_FLASH_READY_POS  = 3;

endpackage

// File: protected_field.sv
`timescale 1ns/1ps
module protected_field #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             wr_en,
  input  wire logic             unlocked,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] value_ff,
  output logic                  blocked
);

  // ==========================================================================
  // Field storage, writes land only while unlocked
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      value_ff <= RESET;
    end else if (wr_en && unlocked) begin
      value_ff <= wr_data;
    end
  end

  // Write that was thrown away because protection was on
  assign blocked = wr_en & ~unlocked;

endmodule

// File: system_protect_and_memory_config.sv
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - Writing key 0x0096 to the protect key register lifts write protection.
// - Any key value other than 0x0096 means protection is enabled.
// - While protected, writes to protected bits are dropped; stored values stay.
// - Unlock persists until a non-key value is written; software re-locks afterwards.
// - Key register is 16-bit read/write, resets to 0x0000, so locked after reset.
// - 3-bit RAM size code: 512B, 1KB, 2KB, 4KB; resets to 0x3; protected.
// - Bit 7 of flash cycle register reads 1 when flash is accessible.
// - In normal operation the flash ready flag shows flash accessible.
// - 2-bit protected read-wait code, reset 0x0, gives 1 to 4 read cycles.
module system_protect_and_memory_config
  import sysprot_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire sysprot_pkg::wb_req_t wb_req,
  output sysprot_pkg::wb_rsp_t      wb_rsp_ff,
  input  wire logic                 flash_hold_pin,
  output logic                      protect_on_ff,
  output logic [2:0]                ram_size_code_ff,
  output logic [15:0]               ram_size_bytes_ff,
  output logic [2:0]                flash_read_cycles_ff,
  output logic                      flash_ready_ff
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [15:0] merge16(
    input logic [15:0]      old_v,
    input logic [31:0]      new_v,
    input logic [SEL_W-1:0] sel
  );
    logic [15:0] res;
    res = old_v;
    if (sel[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  function automatic logic [15:0] ram_bytes(input logic [2:0] code);
    logic [15:0] res;
    res = RAM_MIN_BYTES << code;
    return res;
  endfunction

  function automatic logic ram_code_illegal(input logic [2:0] code);
    return code > RAM_CODE_MAX_LEGAL;
  endfunction

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  logic        access;
  logic        commit;
  logic        wr_commit;
  logic        hit_key;
  logic        hit_ram;
  logic        hit_flash;
  logic        hit_status;
  logic [15:0] key_ff;
  logic [15:0] nxt_key;
  logic        unlocked;
  logic        blocked_wr_ff;
  logic        flash_hold_meta_ff;
  logic        flash_hold_sync_ff;
  logic        out_of_reset_ff;

  assign access     = wb_req.cyc & wb_req.stb;
  // Commit on the edge at which the master sees ack
  assign commit     = access & wb_rsp_ff.ack;
  assign wr_commit  = commit & wb_req.we;
  assign hit_key    = (wb_req.adr == OFS_PROTECT_KEY);
  assign hit_ram    = (wb_req.adr == OFS_RAM_SIZE_SEL);
  assign hit_flash  = (wb_req.adr == OFS_FLASH_CYCLE);
  assign hit_status = (wb_req.adr == OFS_STATUS);

  // ==========================================================================
  // Protection key
  // ==========================================================================
  assign nxt_key  = merge16(key_ff, wb_req.dat, wb_req.sel);
  assign unlocked = (key_ff == PROTECT_UNLOCK_KEY);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      key_ff <= PROTECT_KEY_RESET;
    end else if (wr_commit && hit_key) begin
      key_ff <= nxt_key;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      protect_on_ff <= 1'b1;
    end else if (wr_commit && hit_key) begin
      protect_on_ff <= (nxt_key != PROTECT_UNLOCK_KEY);
    end
  end

  // ==========================================================================
  // Protected fields
  // ==========================================================================
  logic       ram_code_wr;
  logic       ram_rsvd_wr;
  logic       flash_wait_wr;
  logic [2:0] ram_code;
  logic       ram_rsvd;
  logic [1:0] flash_wait;
  logic       ram_code_blk;
  logic       ram_rsvd_blk;
  logic       flash_wait_blk;
  logic       any_blocked;

  // Lane 0 carries the low fields, lane 1 the reserved bit
  assign ram_code_wr   = wr_commit & hit_ram & wb_req.sel[0];
  assign ram_rsvd_wr   = wr_commit & hit_ram & wb_req.sel[1];
  assign flash_wait_wr = wr_commit & hit_flash & wb_req.sel[0];

  protected_field #(
    .WIDTH (RAM_CODE_W),
    .RESET (RAM_CODE_RESET)
  ) u_ram_code (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_en    (ram_code_wr),
    .unlocked (unlocked),
    .wr_data  (wb_req.dat[RAM_CODE_LSB +: RAM_CODE_W]),
    .value_ff (ram_code),
    .blocked  (ram_code_blk)
  );

  protected_field #(
    .WIDTH (1),
    .RESET (RAM_RSVD_WR_RESET)
  ) u_ram_rsvd (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_en    (ram_rsvd_wr),
    .unlocked (unlocked),
    .wr_data  (wb_req.dat[RAM_RSVD_WR_POS]),
    .value_ff (ram_rsvd),
    .blocked  (ram_rsvd_blk)
  );

  protected_field #(
    .WIDTH (FLASH_WAIT_W),
    .RESET (FLASH_WAIT_RESET)
  ) u_flash_wait (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_en    (flash_wait_wr),
    .unlocked (unlocked),
    .wr_data  (wb_req.dat[FLASH_WAIT_LSB +: FLASH_WAIT_W]),
    .value_ff (flash_wait),
    .blocked  (flash_wait_blk)
  );

  assign any_blocked = ram_code_blk | ram_rsvd_blk | flash_wait_blk;

  // ==========================================================================
  // Derived configuration outputs
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ram_size_code_ff  <= RAM_CODE_RESET;
      ram_size_bytes_ff <= ram_bytes(RAM_CODE_RESET);
    end else begin
      ram_size_code_ff  <= ram_code;
      ram_size_bytes_ff <= ram_bytes(ram_code);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_read_cycles_ff <= {1'b0, FLASH_WAIT_RESET} + 3'h1;
    end else begin
      flash_read_cycles_ff <= {1'b0, flash_wait} + 3'h1;
    end
  end

  // ==========================================================================
  // Flash ready
  // ==========================================================================
  // Hold request from outside is synchronised before use
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_hold_meta_ff <= 1'b0;
      flash_hold_sync_ff <= 1'b0;
    end else begin
      flash_hold_meta_ff <= flash_hold_pin;
      flash_hold_sync_ff <= flash_hold_meta_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_of_reset_ff <= 1'b0;
    end else begin
      out_of_reset_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_ready_ff <= FLASH_READY_RESET;
    end else begin
      flash_ready_ff <= out_of_reset_ff & ~flash_hold_sync_ff;
    end
  end

  // ==========================================================================
  // Status: blocked-write sticky flag, write one to clear
  // ==========================================================================
  logic blocked_clr;

  assign blocked_clr = wr_commit & hit_status & wb_req.sel[0] & wb_req.dat[STAT_BLOCKED_WR_POS];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blocked_wr_ff <= 1'b0;
    end else if (any_blocked) begin
      blocked_wr_ff <= 1'b1;
    end else if (blocked_clr) begin
      blocked_wr_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Read mux
  // ==========================================================================
  logic [15:0] rd_key;
  logic [15:0] rd_ram;
  logic [15:0] rd_flash;
  logic [15:0] rd_status;
  logic [31:0] rd_data;

  always_comb begin
    rd_key = key_ff;
  end

  always_comb begin
    rd_ram = 16'h0000;
    rd_ram[RAM_CODE_LSB +: RAM_CODE_W]    = ram_code;
    rd_ram[RAM_RSVD_RO_LSB +: RAM_CODE_W] = RAM_RSVD_RO_VALUE;
    rd_ram[RAM_RSVD_WR_POS]               = ram_rsvd;
  end

  always_comb begin
    rd_flash = 16'h0000;
    rd_flash[FLASH_WAIT_LSB +: FLASH_WAIT_W] = flash_wait;
    rd_flash[FLASH_READY_POS]                = flash_ready_ff;
  end

  always_comb begin
    rd_status = 16'h0000;
    rd_status[STAT_PROTECT_ON_POS]  = protect_on_ff;
    rd_status[STAT_BLOCKED_WR_POS]  = blocked_wr_ff;
    rd_status[STAT_RAM_ILLEGAL_POS] = ram_code_illegal(ram_code);
    rd_status[STAT_FLASH_READY_POS] = flash_ready_ff;
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_key) begin
      rd_data[15:0] = rd_key;
    end else if (hit_ram) begin
      rd_data[15:0] = rd_ram;
    end else if (hit_flash) begin
      rd_data[15:0] = rd_flash;
    end else if (hit_status) begin
      rd_data[15:0] = rd_status;
    end
  end

  // ==========================================================================
  // Bus answer: ack one cycle after request, then dropped
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_rsp_ff.ack <= 1'b0;
    end else begin
      wb_rsp_ff.ack <= access & ~wb_rsp_ff.ack;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_rsp_ff.dat <= 32'h0000_0000;
    end else if (access && !wb_rsp_ff.ack && !wb_req.we) begin
      wb_rsp_ff.dat <= rd_data;
    end else if (!access) begin
      wb_rsp_ff.dat <= 32'h0000_0000;
    end
  end

endmodule

// File: sysprot_chk.sv
`timescale 1ns/1ps
module sysprot_chk
  import sysprot_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire sysprot_pkg::wb_req_t wb_req,
  input wire sysprot_pkg::wb_rsp_t wb_rsp_ff,
  input wire logic                 flash_hold_pin,
  input wire logic                 protect_on_ff,
  input wire logic [2:0]           ram_size_code_ff,
  input wire logic [15:0]          ram_size_bytes_ff,
  input wire logic [2:0]           flash_read_cycles_ff,
  input wire logic                 flash_ready_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================================
  // Accepted write at the ack edge
  sequence s_wr(logic [ADDR_W-1:0] a);
    wb_rsp_ff.ack && wb_req.cyc && wb_req.stb && wb_req.we && wb_req.adr == a;
  endsequence

  a_ack_latency: assert property ($rose(wb_req.stb) && wb_req.cyc |=> wb_rsp_ff.ack)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_rsp_ff.ack |=> !wb_rsp_ff.ack)
    else $error("ack longer than one cycle");
  a_reset_state: assert property ($rose(rst_b) |-> protect_on_ff &&
    ram_size_code_ff == 3'h3 && flash_read_cycles_ff == 3'h1) else $error("bad reset state");
  a_key_unlock: assert property (s_wr(OFS_PROTECT_KEY) ##0 (wb_req.sel[1:0] == 2'h3 &&
    wb_req.dat[15:0] == PROTECT_UNLOCK_KEY) |=> !protect_on_ff) else $error("key did not unlock");
  a_key_relock: assert property (s_wr(OFS_PROTECT_KEY) ##0 (wb_req.sel[1:0] == 2'h3 &&
    wb_req.dat[15:0] != PROTECT_UNLOCK_KEY) |=> protect_on_ff) else $error("key did not lock");
  a_lock_cause: assert property ($changed(protect_on_ff) && $past(rst_b) |->
    $past(wb_rsp_ff.ack && wb_req.we && wb_req.adr == OFS_PROTECT_KEY))
    else $error("protection changed without key write");
  a_locked_hold: assert property (s_wr(OFS_RAM_SIZE_SEL) ##0 protect_on_ff |=>
    $stable(ram_size_code_ff) [*2]) else $error("locked write changed ram code");
  a_ram_write: assert property (s_wr(OFS_RAM_SIZE_SEL) ##0 (!protect_on_ff && wb_req.sel[0])
    |-> ##2 ram_size_code_ff == $past(wb_req.dat[2:0], 2)) else $error("ram code not written");
  a_wait_write: assert property (s_wr(OFS_FLASH_CYCLE) ##0 (!protect_on_ff && wb_req.sel[0])
    |-> ##2 flash_read_cycles_ff == {1'b0, $past(wb_req.dat[1:0], 2)} + 3'h1)
    else $error("read cycles wrong");
  a_bytes_map: assert property (ram_size_code_ff <= 3'h3 |->
    ram_size_bytes_ff == (16'h0200 << ram_size_code_ff)) else $error("ram bytes wrong");
  a_ready_on: assert property ((!flash_hold_pin) [*8] |-> flash_ready_ff)
    else $error("flash not ready");
  a_ready_off: assert property (flash_hold_pin [*8] |-> !flash_ready_ff)
    else $error("flash ready while held");
endmodule

bind system_protect_and_memory_config sysprot_chk chk_inst (
  .clk                  (clk),
  .rst_b                (rst_b),
  .wb_req               (wb_req),
  .wb_rsp_ff            (wb_rsp_ff),
  .flash_hold_pin       (flash_hold_pin),
  .protect_on_ff        (protect_on_ff),
  .ram_size_code_ff     (ram_size_code_ff),
  .ram_size_bytes_ff    (ram_size_bytes_ff),
  .flash_read_cycles_ff (flash_read_cycles_ff),
  .flash_ready_ff       (flash_ready_ff)
);

// File: system_protect_and_memory_config_tb.sv
`timescale 1ns/1ps
module system_protect_and_memory_config_tb;
  import sysprot_pkg::*;
  logic        clk;
  logic        rst_b;
  wb_req_t     req;
  wb_rsp_t     rsp;
  logic        hold;
  logic        prot_on;
  logic [2:0]  ram_code;
  logic [15:0] ram_bytes;
  logic [2:0]  rd_cycles;
  logic        ready;
  logic [31:0] q;
  int          error_cnt;
  int          num_checks;

  system_protect_and_memory_config system_protect_and_memory_config_inst (
    .clk                  (clk),
    .rst_b                (rst_b),
    .wb_req               (req),
    .wb_rsp_ff            (rsp),
    .flash_hold_pin       (hold),
    .protect_on_ff        (prot_on),
    .ram_size_code_ff     (ram_code),
    .ram_size_bytes_ff    (ram_bytes),
    .flash_read_cycles_ff (rd_cycles),
    .flash_ready_ff       (ready)
  );

  always #2.5 clk = ~clk;

  // ==========================================================================
  // Shared tasks
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    q = rsp.dat;
    if (rsp.ack === 1'b1) begin
      n = 0;
    end
    req <= '0;
    @(posedge clk);
    if (n >= 50) begin
      error_cnt++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(q, exp);
  endtask

  task automatic pchk(input logic p, input logic [2:0] c, input logic [2:0] w,
                      input logic r);
    repeat (2) @(posedge clk);
    chk({8'h00, prot_on, ram_code, ram_bytes, rd_cycles, ready},
        {8'h00, p, c, 16'h0200 << c, w, r});
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_defaults();
    rd(OFS_PROTECT_KEY, 32'h0000_0000);
    rd(OFS_RAM_SIZE_SEL, 32'h0000_0033);
    rd(OFS_FLASH_CYCLE, 32'h0000_0080);
    pchk(1'b1, 3'h3, 3'h1, 1'b1);
  endtask

  task automatic t_locked();
    bus(1'b1, OFS_PROTECT_KEY, 32'h0000_0095, 4'h3);
    bus(1'b1, OFS_RAM_SIZE_SEL, 32'h0000_0001, 4'h3);
    bus(1'b1, OFS_FLASH_CYCLE, 32'h0000_0003, 4'h3);
    rd(OFS_RAM_SIZE_SEL, 32'h0000_0033);
    rd(OFS_FLASH_CYCLE, 32'h0000_0080);
    rd(OFS_PROTECT_KEY, 32'h0000_0095);
    rd(OFS_STATUS, 32'h0000_000B);
    pchk(1'b1, 3'h3, 3'h1, 1'b1);
  endtask

  task automatic t_unlock();
    bus(1'b1, OFS_PROTECT_KEY, 32'hFFFF_0096, 4'hF);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_RAM_SIZE_SEL, 32'(i), 4'h1);
      rd(OFS_RAM_SIZE_SEL, 32'h0000_0030 | 32'(i));
      bus(1'b1, OFS_FLASH_CYCLE, 32'(i), 4'h1);
      rd(OFS_FLASH_CYCLE, 32'h0000_0080 | 32'(i));
      pchk(1'b0, 3'(i), 3'(i + 1), 1'b1);
    end
    bus(1'b1, OFS_RAM_SIZE_SEL, 32'h0000_FFFF, 4'h3);
    rd(OFS_RAM_SIZE_SEL, 32'h0000_0137);
    rd(OFS_STATUS, 32'h0000_000E);
    bus(1'b1, OFS_STATUS, 32'h0000_0002, 4'h1);
    rd(OFS_STATUS, 32'h0000_000C);
    bus(1'b1, OFS_FLASH_CYCLE, 32'h0000_FFFF, 4'h3);
    rd(OFS_FLASH_CYCLE, 32'h0000_0083);
    bus(1'b1, OFS_RAM_SIZE_SEL, 32'h0000_0002, 4'h3);
    bus(1'b1, OFS_PROTECT_KEY, 32'h0000_0000, 4'h3);
    bus(1'b1, OFS_RAM_SIZE_SEL, 32'h0000_0001, 4'h3);
    rd(OFS_RAM_SIZE_SEL, 32'h0000_0032);
    rd(OFS_STATUS, 32'h0000_000B);
    pchk(1'b1, 3'h2, 3'h4, 1'b1);
  endtask

  task automatic t_bytes();
    bus(1'b1, OFS_PROTECT_KEY, 32'h0000_0096, 4'h1);
    pchk(1'b0, 3'h2, 3'h4, 1'b1);
    bus(1'b1, OFS_PROTECT_KEY, 32'h0000_0100, 4'h2);
    rd(OFS_PROTECT_KEY, 32'h0000_0196);
    pchk(1'b1, 3'h2, 3'h4, 1'b1);
    bus(1'b1, 8'h40, 32'h0000_FFFF, 4'hF);
    rd(8'h40, 32'h0000_0000);
  endtask

  task automatic t_hold();
    hold <= 1'b1;
    repeat (12) @(posedge clk);
    rd(OFS_FLASH_CYCLE, 32'h0000_0003);
    hold <= 1'b0;
    repeat (12) @(posedge clk);
    rd(OFS_FLASH_CYCLE, 32'h0000_0083);
  endtask

  task automatic t_rereset();
    bus(1'b1, OFS_PROTECT_KEY, 32'h0000_0096, 4'h3);
    bus(1'b1, OFS_RAM_SIZE_SEL, 32'h0000_0000, 4'h3);
    pchk(1'b0, 3'h0, 3'h4, 1'b1);
    do_reset();
    t_defaults();
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    req = '0;
    hold = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    do_reset();
    t_defaults();
    t_locked();
    t_unlock();
    t_bytes();
    t_hold();
    t_rereset();
    conclude();
  end
endmodule
